// file: bench/flyback_multimode_pwm_control_test.sv
// Purpose: Self-checking bench for the PWM control core
// Assumes: Power stage model drives the sense comparators
// Notes: Open-loop and undervoltage delays shortened to 200
`timescale 1ns/1ps
module flyback_multimode_pwm_control_test;
   import fmp_pkg::*;
   localparam int OLC = 200;
   localparam int UVC = 200;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic supplyOnCmp = 1'b0, supplyLowCmp = 1'b1, supplyKeepCmp = 1'b0, supplyOverCmp = 1'b0;
   logic burstLowCmp = 1'b0, openLoopCmp = 1'b0, pinFaultCmp = 1'b0, outOver = 1'b0, outShort = 1'b0;
   logic [7:0] feedbackLevel = 8'hff, peakCyc = 8'h10, ringCyc = 8'h05;
   logic valleyCmp, currentLimitCmp, plateauOverCmp, detectUnderCmp, gateOut, running, faultLatched;
   fmp_mode_e mode;
   int fails = 0, checks = 0, pulses, minPer, maxPer, minOn;
   // 50 MHz clock
   always #10 sys_clk = ~sys_clk;
   fmp_power_stage i_stage (.sys_clk(sys_clk), .gateOut(gateOut), .peakCyc(peakCyc), .ringCyc(ringCyc),
      .outOver(outOver), .outShort(outShort), .valleyCmp(valleyCmp), .currentLimitCmp(currentLimitCmp),
      .plateauOverCmp(plateauOverCmp), .detectUnderCmp(detectUnderCmp));
   fmp_control #(.OPEN_LOOP_CYCLES(OLC), .UNDER_CYCLES(UVC), .SAMPLE_DELAY_CYC(100)) i_dut (
      .sys_clk(sys_clk), .reset(reset), .supplyOnCmp(supplyOnCmp), .supplyLowCmp(supplyLowCmp),
      .supplyKeepCmp(supplyKeepCmp), .supplyOverCmp(supplyOverCmp), .valleyCmp(valleyCmp),
      .plateauOverCmp(plateauOverCmp), .detectUnderCmp(detectUnderCmp), .burstLowCmp(burstLowCmp),
      .openLoopCmp(openLoopCmp), .currentLimitCmp(currentLimitCmp), .pinFaultCmp(pinFaultCmp),
      .feedbackLevel(feedbackLevel), .gateOut(gateOut), .running(running), .faultLatched(faultLatched),
      .mode(mode));
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task print_verdict;
      if (fails == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Pulse statistics; a fresh random peak current at every turn-on
   task measure(input int n);
      logic g, gp;
      int per, on;
      gp = gateOut;
      per = 0;
      on = 0;
      pulses = 0;
      minPer = 99999;
      maxPer = 0;
      minOn = 99999;
      repeat (n) begin
         @(negedge sys_clk);
         g = gateOut;
         per++;
         if (g !== 1'b1 && gp === 1'b1 && pulses > 0 && on < minOn) minOn = on;
         on = (g === 1'b1) ? on + 1 : 0;
         gp = g;
         if (g === 1'b1 && on == 1) begin
            if (pulses > 0 && per < minPer) minPer = per;
            if (pulses > 0 && per > maxPer) maxPer = per;
            pulses++;
            per = 0;
            @(posedge sys_clk);
            peakCyc <= 8'($urandom_range(60, 4));
         end
      end
   endtask
   // Bounded wait for the protection latch, with its earliest moment
   task wait_fault(input int lo, input int hi);
      int n;
      n = 0;
      while (faultLatched !== 1'b1 && n <= hi) begin
         @(negedge sys_clk);
         n++;
      end
      check("faultWait", n <= hi, 1);
      if (n > hi) print_verdict();
      else check("faultDelay", n >= lo, 1);
   endtask
   // Supply falls below lockout, then climbs past the upper threshold
   task relock;
      @(posedge sys_clk);
      supplyLowCmp <= 1'b1;
      cyc(3);
      @(negedge sys_clk);
      check("running", running, 0);
      @(posedge sys_clk);
      supplyLowCmp <= 1'b0;
      supplyOnCmp <= 1'b1;
      cyc(3);
      @(negedge sys_clk);
      check("running", running, 1);
      check("faultLatched", faultLatched, 0);
      @(posedge sys_clk);
      supplyOnCmp <= 1'b0;
   endtask
   // One protection: 0 short, 1 open loop, 2 plateau over, 3 supply over
   task trip(input int k, input int lo, input int hi);
      @(posedge sys_clk);
      outShort <= (k == 0);
      openLoopCmp <= (k == 1);
      outOver <= (k == 2);
      supplyOverCmp <= (k == 3);
      wait_fault(lo, hi);
      measure(300);
      check("pulses", pulses, 0);
      @(posedge sys_clk);
      {outShort, openLoopCmp, outOver, supplyOverCmp} <= 4'h0;
      cyc(50);
      @(negedge sys_clk);
      check("faultLatched", faultLatched, 1);
      relock();
   endtask
   initial begin
      void'($urandom(61));
      cyc(6);
      reset <= 1'b0;
      @(negedge sys_clk);
      check("gateOut", gateOut, 0);
      check("mode", mode, MODE_OFF);
      relock();
      measure(5000);
      check("pulses", pulses > 3, 1);
      check("minOn", minOn >= BLANK_CYC, 1);
      check("minPer", minPer >= MAX_PERIOD_CYC, 1);
      @(posedge sys_clk);
      ringCyc <= 8'h00;
      measure(4000);
      check("maxPer", maxPer <= CCM_PERIOD_CYC + 4, 1);
      check("mode", mode, MODE_CCM);
      @(posedge sys_clk);
      ringCyc <= 8'h05;
      feedbackLevel <= 8'h20;
      measure(6000);
      check("mode", mode, MODE_GREEN);
      check("minPer", minPer > MAX_PERIOD_CYC, 1);
      // No valleys and a green clamp beyond the fixed rate: only the timeout turns on
      @(posedge sys_clk);
      ringCyc <= 8'h00;
      measure(24000);
      check("minPer", minPer >= TIMEOUT_CYC, 1);
      check("maxPer", maxPer <= TIMEOUT_CYC + 80, 1);
      @(posedge sys_clk);
      ringCyc <= 8'h05;
      burstLowCmp <= 1'b1;
      cyc(3);
      @(negedge sys_clk);
      check("gateOut", gateOut, 0);
      measure(400);
      check("pulses", pulses, 0);
      @(posedge sys_clk);
      supplyKeepCmp <= 1'b1;
      measure(2000);
      check("pulses", pulses > 1, 1);
      @(posedge sys_clk);
      {supplyKeepCmp, burstLowCmp, pinFaultCmp} <= 3'h1;
      feedbackLevel <= 8'hff;
      cyc(3);
      @(negedge sys_clk);
      check("gateOut", gateOut, 0);
      measure(400);
      check("pulses", pulses, 0);
      @(posedge sys_clk);
      pinFaultCmp <= 1'b0;
      relock();
      @(posedge sys_clk);
      supplyOverCmp <= 1'b1;
      cyc(VCC_OV_DEB_CYC - 400);
      supplyOverCmp <= 1'b0;
      cyc(4);
      @(negedge sys_clk);
      check("faultLatched", faultLatched, 0);
      trip(3, VCC_OV_DEB_CYC, VCC_OV_DEB_CYC + 8);
      trip(2, OUT_OV_DEB_CYC, OUT_OV_DEB_CYC + 2000);
      trip(0, UVC, UVC + 8);
      trip(1, OLC, OLC + 8);
      print_verdict();
   end
endmodule

// file: bench/fmp_control_properties.sv
// Purpose: Port assertions for the PWM control core
// Assumes: Comparators pass two sync flops first
// Notes: Run counters stand in for long repetitions
`timescale 1ns/1ps
module fmp_control_properties
   import fmp_pkg::*;
#(
   parameter int OPEN_LOOP_CYCLES = OPEN_LOOP_CYC,
   parameter int UNDER_CYCLES = UNDER_DEB_CYC,
   parameter int SAMPLE_DELAY_CYC = 100
) (
   input wire logic sys_clk, // Clock
   input wire logic reset, // Sync reset
   input wire logic supplyOnCmp, // Upper supply
   input wire logic supplyLowCmp, // Lower supply
   input wire logic supplyKeepCmp, // Keep level
   input wire logic supplyOverCmp, // Supply over
   input wire logic valleyCmp, // Valley
   input wire logic plateauOverCmp, // Plateau over
   input wire logic detectUnderCmp, // Detect under
   input wire logic burstLowCmp, // Burst level
   input wire logic openLoopCmp, // Open loop
   input wire logic currentLimitCmp, // Current limit
   input wire logic pinFaultCmp, // Pin fault
   input wire logic [FB_W-1:0] feedbackLevel, // Feedback code
   input wire logic gateOut, // Gate drive
   input wire logic running, // Lockout released
   input wire logic faultLatched, // Latched off
   input wire fmp_mode_e mode // Mode
);
   int hiCnt_q, hiCnt_d, loCnt_q, loCnt_d;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Gate high run, and low run while nothing holds the gate off
   always_comb begin
      hiCnt_d = gateOut ? hiCnt_q + 1 : 0;
      loCnt_d = (running && !gateOut && !faultLatched && !burstLowCmp && !pinFaultCmp) ? loCnt_q + 1 : 0;
   end
   // Cleared in reset so no stale run leaks into a new start
   always_ff @(posedge sys_clk) begin
      hiCnt_q <= reset ? 0 : hiCnt_d;
      loCnt_q <= reset ? 0 : loCnt_d;
   end
   a_reset_clears: assert property (
      $fell(reset) |-> !gateOut && !running && !faultLatched && mode == MODE_OFF)
      else $error("outputs not cleared by reset");
   a_start_upper: assert property ($rose(running) |-> $past(supplyOnCmp, 3))
      else $error("running rose without upper supply");
   a_stop_lower: assert property (supplyLowCmp [*4] |-> !running)
      else $error("running kept below lower supply");
   a_pin_fault_off: assert property (pinFaultCmp [*4] |-> !gateOut)
      else $error("gate on during pin fault");
   a_burst_gate_off: assert property ((burstLowCmp && !supplyKeepCmp) [*4] |-> !gateOut)
      else $error("gate on in burst level");
   a_blank_holds_gate: assert property (
      $fell(gateOut) && running && !faultLatched && !pinFaultCmp && !$past(pinFaultCmp, 3)
      && !burstLowCmp && !$past(burstLowCmp, 3) |-> hiCnt_q >= BLANK_CYC)
      else $error("pulse ended inside blanking");
   a_timeout_bound: assert property (loCnt_q <= TIMEOUT_CYC + 4)
      else $error("gate low past turn-on timeout");
   a_fault_holds_off: assert property (faultLatched && $past(faultLatched) |-> !gateOut)
      else $error("gate on while fault latched");
   c_start: cover property ($rose(running));
   c_trip: cover property ($rose(faultLatched));
   c_green: cover property (mode == MODE_GREEN && $rose(gateOut));
endmodule
bind fmp_control fmp_control_properties #(.OPEN_LOOP_CYCLES(OPEN_LOOP_CYCLES), .UNDER_CYCLES(UNDER_CYCLES),
   .SAMPLE_DELAY_CYC(SAMPLE_DELAY_CYC)) i_props (.sys_clk(sys_clk), .reset(reset), .supplyOnCmp(supplyOnCmp),
   .supplyLowCmp(supplyLowCmp), .supplyKeepCmp(supplyKeepCmp), .supplyOverCmp(supplyOverCmp),
   .valleyCmp(valleyCmp), .plateauOverCmp(plateauOverCmp), .detectUnderCmp(detectUnderCmp),
   .burstLowCmp(burstLowCmp), .openLoopCmp(openLoopCmp), .currentLimitCmp(currentLimitCmp),
   .pinFaultCmp(pinFaultCmp), .feedbackLevel(feedbackLevel), .gateOut(gateOut), .running(running),
   .faultLatched(faultLatched), .mode(mode));

// file: bench/fmp_power_stage.sv
// Purpose: Switch, sense resistor and auxiliary winding model
// Assumes: Gate drive seen on sys_clk edges
// Notes: Fixed plateau, then one valley every ringCyc cycles
`timescale 1ns/1ps
module fmp_power_stage #(
   parameter int DEMAG = 150
) (
   input wire logic sys_clk, // Clock
   input wire logic gateOut, // Gate drive
   input wire logic [7:0] peakCyc, // On cycles to limit
   input wire logic [7:0] ringCyc, // Valley spacing, 0 none
   input wire logic outOver, // Output too high
   input wire logic outShort, // Output shorted
   output logic valleyCmp, // Valley seen
   output logic currentLimitCmp, // Current at limit
   output logic plateauOverCmp, // Plateau over level
   output logic detectUnderCmp // Detect pin low
);
   int onCnt = 0;
   int offCnt = 0;
   // Run lengths of the switch state
   always @(posedge sys_clk) begin
      onCnt <= gateOut ? onCnt + 1 : 0;
      offCnt <= gateOut ? 0 : offCnt + 1;
   end
   // Sense ramp crosses the limit after peakCyc on cycles, no turn-on spike modelled
   assign currentLimitCmp = gateOut && onCnt >= peakCyc;
   // Plateau only while the core demagnetises
   assign plateauOverCmp = !gateOut && offCnt < DEMAG && outOver;
   // A shorted output leaves the winding near zero
   assign detectUnderCmp = outShort;
   // No valleys at all when ringCyc is zero, forcing fixed-rate or timeout turn-on
   assign valleyCmp = ringCyc != 0 && !gateOut && offCnt >= DEMAG && (offCnt - DEMAG) % ringCyc == ringCyc - 1;
endmodule

// file: src/fmp_control.sv
// Purpose: Mode selection, gate timing and protection sequencing
// Assumes: Analog comparators outside, supply lockout state here
// Notes: Feedback level arrives as a digital code for the frequency clamp
`timescale 1ns/1ps

module fmp_control
   import fmp_pkg::*;
#(
   parameter int OPEN_LOOP_CYCLES = OPEN_LOOP_CYC,
   parameter int UNDER_CYCLES = UNDER_DEB_CYC,
   parameter int SAMPLE_DELAY_CYC = 100
) (
   input wire logic sys_clk, // System clock, 50 MHz
   input wire logic reset, // Sync reset, active high
   input wire logic supplyOnCmp, // Supply above upper threshold
   input wire logic supplyLowCmp, // Supply below lower threshold
   input wire logic supplyKeepCmp, // Supply at forced-duty entry
   input wire logic supplyOverCmp, // Supply overvoltage comparator
   input wire logic valleyCmp, // Valley seen on valley_detect_pin
   input wire logic plateauOverCmp, // Detect pin above overvoltage level
   input wire logic detectUnderCmp, // Detect pin under 0.5 V level
   input wire logic burstLowCmp, // Feedback below burst level
   input wire logic openLoopCmp, // Feedback above open-loop level
   input wire logic currentLimitCmp, // Current sense at limit
   input wire logic pinFaultCmp, // Any pin fault comparator
   input wire logic [FB_W-1:0] feedbackLevel, // Feedback code
   output logic gateOut, // MOSFET gate drive
   output logic running, // Supply lockout released
   output logic faultLatched, // Protection latched off
   output fmp_mode_e mode // Present operating mode
);
   fmp_sync_if syncBus ();
   logic [10:0] rawCmp;
   logic vccOvTrip, plateauTrip, underTrip, openTrip;
   logic gate_q, gate_d, run_q, run_d, fault_q, fault_d, keep_q, keep_d;
   logic [CNT_W-1:0] phase_q, phase_d, offCnt_q, offCnt_d;
   logic [1:0] valleySeen_q, valleySeen_d;
   logic sampleWin, plateauHeld_q, plateauHeld_d;
   logic [CNT_W-1:0] clampCyc;
   fmp_mode_e mode_q, mode_d;

   // ****************************************
   // Comparator synchronisation
   // ****************************************
   assign rawCmp = {pinFaultCmp, currentLimitCmp, openLoopCmp, burstLowCmp, detectUnderCmp,
      plateauOverCmp, valleyCmp, supplyOverCmp, supplyKeepCmp, supplyLowCmp, supplyOnCmp};
   fmp_sync #(.N(11)) uSync (
      .sys_clk(sys_clk),
      .reset(reset),
      .rawIn(rawCmp),
      .syncOut(syncBus.src)
   );

   // ****************************************
   // Protection debounce
   // ****************************************
   // Supply overvoltage debounce
   fmp_debounce #(.LIMIT(VCC_OV_DEB_CYC)) uVccOv (
      .sys_clk(sys_clk),
      .reset(reset),
      .enable(run_q),
      .level(syncBus.supplyOver),
      .trip(vccOvTrip)
   );
   assign sampleWin = !gate_q && offCnt_q == CNT_W'(SAMPLE_DELAY_CYC);
   fmp_debounce #(.LIMIT(OUT_OV_DEB_CYC)) uPlateau (
      .sys_clk(sys_clk),
      .reset(reset),
      .enable(run_q),
      .level(plateauHeld_q),
      .trip(plateauTrip)
   );
   fmp_debounce #(.LIMIT(UNDER_CYCLES)) uUnder (
      .sys_clk(sys_clk),
      .reset(reset),
      .enable(run_q),
      .level(syncBus.detectUnder),
      .trip(underTrip)
   );
   fmp_debounce #(.LIMIT(OPEN_LOOP_CYCLES)) uOpen (
      .sys_clk(sys_clk),
      .reset(reset),
      .enable(run_q),
      .level(syncBus.openLoop),
      .trip(openTrip)
   );

   // Frequency clamp as period, linear in green band
   function automatic logic [CNT_W-1:0] clamp_period(input logic [FB_W-1:0] fb);
      logic [CNT_W-1:0] span;
      span = CNT_W'(GREEN_PERIOD_CYC - MAX_PERIOD_CYC);
      if (fb >= FB_MAXCLAMP) begin
         clamp_period = CNT_W'(MAX_PERIOD_CYC);
      end else begin
         clamp_period = CNT_W'(MAX_PERIOD_CYC) + CNT_W'((span * CNT_W'(FB_MAXCLAMP - fb))
            / CNT_W'(FB_MAXCLAMP));
      end
   endfunction
   assign clampCyc = clamp_period(feedbackLevel);

   // Light load reads as green mode, otherwise plain valley switching
   function automatic fmp_mode_e load_mode(input logic [FB_W-1:0] fb);
      load_mode = (fb < FB_GREEN) ? MODE_GREEN : MODE_VALLEY;
   endfunction

   // ****************************************
   // Lockout and fault latch
   // ****************************************
   always_comb begin
      run_d = run_q;
      fault_d = fault_q;
      keep_d = keep_q;
      plateauHeld_d = plateauHeld_q;
      if (!run_q && syncBus.supplyOn) begin
         run_d = 1'b1;
         fault_d = 1'b0;
      end else if (run_q && syncBus.supplyLow) begin
         run_d = 1'b0;
      end
      if (vccOvTrip || plateauTrip || underTrip || openTrip) begin
         fault_d = 1'b1;
      end
      keep_d = syncBus.supplyKeep && syncBus.burstLow;
      // One plateau sample per off time, held until the next
      // Raw plateau lasts only part of each off time, so the held
      // sample is what lets the debounce run across gate pulses
      if (!run_q) begin
         plateauHeld_d = 1'b0;
      end else if (sampleWin) begin
         plateauHeld_d = syncBus.plateauOver;
      end
   end

   // ****************************************
   // Gate timing and mode selection
   // ****************************************
   always_comb begin
      gate_d = gate_q;
      phase_d = phase_q + 1'b1;
      offCnt_d = gate_q ? '0 : offCnt_q + 1'b1;
      valleySeen_d = valleySeen_q;
      mode_d = mode_q;
      if (!run_q || fault_q || syncBus.pinFault) begin
         // Pin fault stops gate at once
         gate_d = 1'b0;
         mode_d = MODE_OFF;
         phase_d = '0;
      end else if (keep_q) begin
         mode_d = MODE_BURST;
         gate_d = phase_q < CNT_W'(FORCED_ON_CYC);
         if (phase_q >= CNT_W'(CCM_PERIOD_CYC - 1)) begin
            phase_d = '0;
         end
      end else if (syncBus.burstLow) begin
         gate_d = 1'b0;
         mode_d = MODE_BURST;
      end else if (gate_q) begin
         if (syncBus.currentLimit && phase_q >= CNT_W'(BLANK_CYC)) begin
            gate_d = 1'b0;
            valleySeen_d = '0;
         end
      end else begin
         // Mode changes only at a turn-on, so fixed rate stays visible while off
         // Valley detector counts valleys
         if (syncBus.valley && valleySeen_q != 2'd3) begin
            valleySeen_d = valleySeen_q + 1'b1;
         end
         // Turn on at valley when clamp allows
         // Valleys inside the clamp period are skipped; green
         if (syncBus.valley && phase_q >= clampCyc) begin
            gate_d = 1'b1;
            phase_d = '0;
            mode_d = load_mode(feedbackLevel);
         // Fixed rate if valley too late
         end else if (phase_q >= CNT_W'(CCM_PERIOD_CYC - 1) && clampCyc <= CNT_W'(CCM_PERIOD_CYC)) begin
            gate_d = 1'b1;
            phase_d = '0;
            mode_d = MODE_CCM;
         end else if (offCnt_q >= CNT_W'(TIMEOUT_CYC - 1)) begin
            gate_d = 1'b1;
            phase_d = '0;
            mode_d = load_mode(feedbackLevel);
         end
      end
   end

   // Registers for control state
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         gate_q <= 1'b0;
         run_q <= 1'b0;
         fault_q <= 1'b0;
         keep_q <= 1'b0;
         phase_q <= '0;
         offCnt_q <= '0;
         plateauHeld_q <= 1'b0;
         valleySeen_q <= '0;
         mode_q <= MODE_OFF;
      end else begin
         gate_q <= gate_d;
         run_q <= run_d;
         fault_q <= fault_d;
         keep_q <= keep_d;
         phase_q <= phase_d;
         offCnt_q <= offCnt_d;
         plateauHeld_q <= plateauHeld_d;
         valleySeen_q <= valleySeen_d;
         mode_q <= mode_d;
      end
   end

   // Outputs straight from flops
   assign gateOut = gate_q;
   assign running = run_q;
   assign faultLatched = fault_q;
   assign mode = mode_q;
endmodule

// file: src/fmp_debounce.sv
// Purpose: Debounce counter, trips after a level holds a set time
// Assumes: Level already synchronised
// Notes: Any drop of the level restarts the count
`timescale 1ns/1ps
module fmp_debounce
   import fmp_pkg::*;
#(
   parameter int LIMIT = 16
) (
   input wire logic sys_clk, // System clock
   input wire logic reset, // Sync reset, active high
   input wire logic enable, // Counting allowed
   input wire logic level, // Condition being watched
   output logic trip // Held long enough, one-cycle pulse
);
   logic [CNT_W-1:0] count_q, count_d;
   logic trip_d;

   // Count while the level stays, restart otherwise
   always_comb begin
      count_d = '0;
      trip_d = 1'b0;
      if (enable && level) begin
         count_d = count_q + 1'b1;
         if (count_q == CNT_W'(LIMIT - 1)) begin
            trip_d = 1'b1;
            count_d = '0;
         end
      end
   end

   // Registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         count_q <= '0;
         trip <= 1'b0;
      end else begin
         count_q <= count_d;
         trip <= trip_d;
      end
   end
endmodule

// file: src/fmp_pkg.sv
// Purpose: Shared constants for the multi-mode flyback PWM control block
// Assumes: 50 MHz sys_clk, comparator inputs asynchronous until fmp_sync
// Notes: Times kept in their own unit, cycle counts derived here
package fmp_pkg;
   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int CLK_HZ = 50000000;
   localparam int CLK_NS = 20;
   localparam int CCM_FREQ_KHZ = 65;
   localparam int MAX_FREQ_KHZ = 69;
   localparam int GREEN_FREQ_KHZ = 25;
   localparam int TIMEOUT_US = 150;
   localparam int BLANK_NS = 350;
   localparam int VCC_OV_DEB_US = 128;
   localparam int OUT_OV_DEB_US = 128;
   localparam int UNDER_DEB_MS = 8;
   localparam int OPEN_LOOP_MS = 69;
   localparam int FORCED_DUTY_PCT = 25;
   // Least times round up, longest times round down
   localparam int CCM_PERIOD_CYC = CLK_HZ / (CCM_FREQ_KHZ * 1000);
   localparam int MAX_PERIOD_CYC = (CLK_HZ + MAX_FREQ_KHZ * 1000 - 1) / (MAX_FREQ_KHZ * 1000);
   localparam int GREEN_PERIOD_CYC = (CLK_HZ + GREEN_FREQ_KHZ * 1000 - 1) / (GREEN_FREQ_KHZ * 1000);
   localparam int TIMEOUT_CYC = TIMEOUT_US * (CLK_HZ / 1000000);
   localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
   localparam int VCC_OV_DEB_CYC = VCC_OV_DEB_US * (CLK_HZ / 1000000);
   localparam int OUT_OV_DEB_CYC = OUT_OV_DEB_US * (CLK_HZ / 1000000);
   localparam int UNDER_DEB_CYC = UNDER_DEB_MS * (CLK_HZ / 1000);
   localparam int OPEN_LOOP_CYC = OPEN_LOOP_MS * (CLK_HZ / 1000);
   localparam int FORCED_ON_CYC = CCM_PERIOD_CYC * FORCED_DUTY_PCT / 100;
   localparam int CNT_W = 24;
   localparam int FB_W = 8;
   // Feedback codes: green and full-clamp breakpoints
   localparam logic [7:0] FB_GREEN = 8'h45;
   localparam logic [7:0] FB_MAXCLAMP = 8'h57;

   // ****************************************
   // Operating modes
   // ****************************************
   typedef enum logic [4:0] {
      MODE_OFF   = 5'h01,
      MODE_VALLEY = 5'h02,
      MODE_CCM   = 5'h04,
      MODE_GREEN = 5'h08,
      MODE_BURST = 5'h10
   } fmp_mode_e;
endpackage

// file: src/fmp_sync.sv
// Purpose: Two-stage synchronisers for every comparator result
// Assumes: Inputs may change at any time
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module fmp_sync
   import fmp_pkg::*;
#(
   parameter int N = 11
) (
   input wire logic sys_clk, // System clock
   input wire logic reset, // Sync reset, active high
   input wire logic [N-1:0] rawIn, // Raw comparator levels
   fmp_sync_if.src syncOut // Synchronised levels
);
   logic [N-1:0] stage1_q, stage1_d, stage2_q, stage2_d;

   // ****************************************
   // Synchroniser stages
   // ****************************************
   // Next values
   always_comb begin
      stage1_d = rawIn;
      stage2_d = stage1_q;
   end

   // Registers, cleared on reset
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         stage1_q <= '0;
         stage2_q <= '0;
      end else begin
         stage1_q <= stage1_d;
         stage2_q <= stage2_d;
      end
   end

   // Fan out to named levels
   assign syncOut.supplyOn = stage2_q[0];
   assign syncOut.supplyLow = stage2_q[1];
   assign syncOut.supplyKeep = stage2_q[2];
   assign syncOut.supplyOver = stage2_q[3];
   assign syncOut.valley = stage2_q[4];
   assign syncOut.plateauOver = stage2_q[5];
   assign syncOut.detectUnder = stage2_q[6];
   assign syncOut.burstLow = stage2_q[7];
   assign syncOut.openLoop = stage2_q[8];
   assign syncOut.currentLimit = stage2_q[9];
   assign syncOut.pinFault = stage2_q[10];
endmodule

// file: src/fmp_sync_if.sv
// Purpose: Carries synchronised comparator levels between modules
// Assumes: One clock domain
// Notes: Filled by the synchroniser, read by the control core
`timescale 1ns/1ps
interface fmp_sync_if;
   logic supplyOn;
   logic supplyLow;
   logic supplyKeep;
   logic supplyOver;
   logic valley;
   logic plateauOver;
   logic detectUnder;
   logic burstLow;
   logic openLoop;
   logic currentLimit;
   logic pinFault;
   modport src (output supplyOn, supplyLow, supplyKeep, supplyOver, valley, plateauOver,
      detectUnder, burstLow, openLoop, currentLimit, pinFault);
   modport dst (input supplyOn, supplyLow, supplyKeep, supplyOver, valley, plateauOver,
      detectUnder, burstLow, openLoop, currentLimit, pinFault);
endinterface
